// File: hdl/i2c_cfg_port.sv
// Two-wire slave port to the configuration registers of a clock generator
// Summary of operation
// R1: Answers as slave at one of two selectable addresses.
// R2: Registers are reached only by block writes and block reads of bytes.
// R3: First byte after write address loads the register pointer.
// R4: Pointer increments after each byte; bits travel most significant first.
// R5: A block may end after any complete byte.
// R6: Written bytes are staged and committed together on STOP.
// R7: Master keeps serial clock between 10 and 400 kHz.
// R8: Current read uses pointer; sequential read sets pointer then repeated START.
// R9: Restore registers first; acknowledge address only once ready.
// R10: Address is primary by default, alternate when select bit is set.
`timescale 1ns/1ns
`default_nettype none
module i2c_cfg_port
    import i2c_cfg_pkg::*;
#(
    parameter int regs = i2c_cfg_pkg::reg_count
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Non-volatile restore
    input  wire logic       restore_valid,
    input  wire logic [7:0] restore_addr,
    input  wire logic [7:0] restore_data,
    input  wire logic       restore_done,
    input  wire logic       addr_select,
    // Register contents to the clock core
    output logic [7:0]      cfg_addr,
    output logic [7:0]      cfg_data,
    output logic            cfg_update,
    output logic            ready
);
    import i2c_cfg_pkg::*;

    // ****************************************
    // Reset and pin synchronisers
    // ****************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl       = scl_sync[1];
    assign sda       = sda_sync[1];
    assign scl_rise  = scl && !scl_d;
    assign scl_fall  = !scl && scl_d;
    assign start_det = scl && scl_d && sda_d && !sda;
    assign stop_det  = scl && scl_d && !sda_d && sda;

    // ****************************************
    // Register store and restore
    // ****************************************
    logic [7:0] regfile [regs];
    logic       commit;
    logic       fifo_valid;
    logic [15:0] fifo_data;

    // Address-select bit is sampled after reset release, never under reset
    logic       sel_alt;
    logic [6:0] my_addr;
    assign my_addr = sel_alt ? addr_alternate : addr_primary; // [R10] [R1]

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready   <= 1'b0;
            sel_alt <= 1'b0;
        end
        else if (!ready && restore_done)
        begin
            ready   <= 1'b1;                           // [R9]
            sel_alt <= addr_select;                    // [R10]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!ready && restore_valid)
        begin
            regfile[restore_addr] <= restore_data;     // [R9]
        end
        else if (commit && fifo_valid)
        begin
            regfile[fifo_data[15:8]] <= fifo_data[7:0]; // [R6]
        end
    end

    // ****************************************
    // Bus protocol engine
    // ****************************************
    state_type  state;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       first_byte;
    logic       have_bit;
    logic       push;
    logic       fifo_ready;
    logic       drive_low;
    logic [7:0] tx;
    logic       sda_hold;
    logic [$clog2(hold_cycles+1)-1:0] hold_cnt;

    // Bytes wait in the FIFO, so the whole burst lands in one sweep after STOP
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            commit <= 1'b0;
        end
        else if (stop_det)
        begin
            commit <= 1'b1;                            // [R6]
        end
        else if (!fifo_valid)
        begin
            commit <= 1'b0;
        end
    end

    stage_fifo #(.width(16), .depth(fifo_depth)) staging
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (1'b0),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({ptr, shreg}),
        .out_valid (fifo_valid),
        .out_ready (commit),
        .out_data  (fifo_data)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= st_idle;
            bitcnt     <= 3'h0;
            shreg      <= 8'h00;
            ptr        <= 8'h00;
            first_byte <= 1'b0;
            have_bit   <= 1'b0;
            push       <= 1'b0;
            drive_low  <= 1'b0;
            tx         <= 8'h00;
        end
        else
        begin
            push <= 1'b0;
            if (push)
            begin
                ptr <= ptr + 8'h01;                    // [R4]
            end
            if (start_det)
            begin
                state     <= st_addr;                  // [R8]
                bitcnt    <= 3'h0;
                have_bit  <= 1'b0;
                drive_low <= 1'b0;
            end
            else if (stop_det)
            begin
                state     <= st_idle;                  // [R5]
                drive_low <= 1'b0;
            end
            else
            begin
                case (state)
                    st_addr, st_wbyte:
                    begin
                        if (scl_rise)
                        begin
                            shreg    <= {shreg[6:0], sda}; // [R4]
                            bitcnt   <= bitcnt + 3'h1;
                            have_bit <= 1'b1;
                        end
                        // The fall that closes START has no bit behind it
                        if (scl_fall && have_bit)
                        begin
                            have_bit <= 1'b0;
                        end
                        if (scl_fall && have_bit && bitcnt == 3'h0 && state == st_addr
                            && shreg[7:1] == my_addr && ready)
                        begin
                            drive_low  <= 1'b1;        // [R1] [R9]
                            state      <= st_aack;
                            first_byte <= !shreg[0];
                            tx         <= regfile[ptr];
                        end
                        else if (scl_fall && have_bit && bitcnt == 3'h0 && state == st_addr)
                        begin
                            state <= st_idle;
                        end
                        else if (scl_fall && have_bit && bitcnt == 3'h0)
                        begin
                            drive_low <= fifo_ready || first_byte;
                            state     <= st_wack;
                            if (first_byte)
                            begin
                                ptr <= shreg;          // [R3]
                            end
                            else
                            begin
                                push <= fifo_ready;    // [R6] [R2]
                            end
                            first_byte <= 1'b0;
                        end
                    end
                    st_aack:
                    begin
                        if (scl_fall)
                        begin
                            if (shreg[0])
                            begin
                                state     <= st_rbyte;
                                drive_low <= !tx[bit_last]; // [R4]
                                tx        <= {tx[6:0], 1'b1};
                            end
                            else
                            begin
                                state     <= st_wbyte;
                                drive_low <= 1'b0;
                            end
                        end
                    end
                    st_wack:
                    begin
                        if (scl_fall)
                        begin
                            drive_low <= 1'b0;
                            state     <= st_wbyte;
                        end
                    end
                    st_rbyte:
                    begin
                        if (scl_fall)
                        begin
                            bitcnt <= bitcnt + 3'h1;
                            if (bitcnt == bit_last)
                            begin
                                drive_low <= 1'b0;
                                state     <= st_rack;
                                ptr       <= ptr + 8'h01; // [R4]
                            end
                            else
                            begin
                                drive_low <= !tx[bit_last];
                                tx        <= {tx[6:0], 1'b1};
                            end
                        end
                    end
                    st_rack:
                    begin
                        if (scl_rise)
                        begin
                            // Missing acknowledge ends the read, STOP follows
                            state <= sda ? st_idle : st_aack; // [R8] [R5]
                            tx    <= regfile[ptr];
                        end
                    end
                    default:
                    begin
                        state <= st_idle;
                    end
                endcase
            end
        end
    end

    // Data line changes only after the hold time past the falling clock edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt <= '0;
            sda_hold <= 1'b0;
        end
        else if (scl_fall)
        begin
            hold_cnt <= ($clog2(hold_cycles+1))'(hold_cycles);
        end
        else if (hold_cnt != '0)
        begin
            hold_cnt <= hold_cnt - 1'b1;
        end
        else if (!scl)
        begin
            sda_hold <= drive_low;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = sda_hold;

    // ****************************************
    // Register contents view
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_addr   <= 8'h00;
            cfg_data   <= 8'h00;
            cfg_update <= 1'b0;
        end
        else
        begin
            cfg_update <= commit && fifo_valid;
            cfg_addr   <= fifo_data[15:8];
            cfg_data   <= fifo_data[7:0];
        end
    end
endmodule
`default_nettype wire

// File: hdl/i2c_cfg_pkg.sv
// Constants shared by the two-wire configuration port
package i2c_cfg_pkg;
    localparam logic [6:0] addr_primary   = 7'h6a;  // 0xd4 as an 8-bit write address
    localparam logic [6:0] addr_alternate = 7'h68;  // 0xd0 as an 8-bit write address
    localparam int         data_width     = 8;
    localparam int         reg_count      = 256;
    localparam int         fifo_depth     = 16;
    localparam logic [2:0] bit_last       = 3'h7;
    localparam int         clk_mhz        = 250;
    // Data hold after the falling clock edge that the device must provide
    localparam int         hold_ns        = 300;
    localparam int         hold_cycles    = (hold_ns * clk_mhz + 999) / 1000;
    localparam int         scl_min_khz    = 10;
    localparam int         scl_max_khz    = 400;

    typedef enum logic [2:0]
    {
        st_idle  = 3'b000,
        st_addr  = 3'b001,
        st_aack  = 3'b011,
        st_wbyte = 3'b010,
        st_wack  = 3'b110,
        st_rbyte = 3'b111,
        st_rack  = 3'b101
    } state_type;
endpackage

// File: hdl/stage_fifo.sv
// Staging FIFO holding written bytes until the bus STOP
`timescale 1ns/1ns
`default_nettype none
module stage_fifo
#(
    parameter int width = 16,
    parameter int depth = 16
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [width-1:0]      out_data
);
    localparam int aw = $clog2(depth);

    logic [width-1:0] mem [depth];
    logic [aw:0]      wr_ptr;
    logic [aw:0]      rd_ptr;
    logic [aw:0]      count;
    logic             push;
    logic             pop;

    assign count     = wr_ptr - rd_ptr;
    assign in_ready  = (count != depth[aw:0]);
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[aw-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr[aw-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/i2c_cfg_port_assertions.sv
// Port checks for the two-wire configuration port
`timescale 1ns/1ns
`default_nettype none
module i2c_cfg_port_assertions
    import i2c_cfg_pkg::*;
#(
    parameter int regs = reg_count
)
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Bus and status
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe,
    input wire logic       restore_done,
    input wire logic [7:0] cfg_addr,
    input wire logic       cfg_update,
    input wire logic       ready
);
    // ********
    // Helpers
    // ********
    logic [15:0] since_fall;
    logic        done_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Low-phase counter, saturating so a parked bus never wraps
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            since_fall <= 16'h0000;
        else if (scl_in)
            since_fall <= 16'h0000;
        else if (since_fall != 16'hffff)
            since_fall <= since_fall + 16'h0001;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            done_seen <= 1'b0;
        else if (restore_done)
            done_seen <= 1'b1;
    a_hold_after_fall: assert property (
        $changed(sda_oe) |-> !scl_in && since_fall >= hold_cycles)
        else $error("data moved too soon after clock fell");
    a_oe_high_steady: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved while clock high");
    a_quiet_unready: assert property (
        !ready |-> !sda_oe)
        else $error("bus driven before ready");
    a_ready_after_done: assert property (
        ready |-> done_seen)
        else $error("ready without restore end");
    a_ready_sticky: assert property (
        ready |=> ready)
        else $error("ready dropped");
    a_commit_idle: assert property (
        cfg_update |-> scl_in && sda_in && ready)
        else $error("commit while bus busy");
    a_commit_ascend: assert property (
        cfg_update && $past(cfg_update) |-> cfg_addr == 8'(($past(cfg_addr) + 1) % regs))
        else $error("commit address not ascending");
    a_commit_burst: assert property (
        $fell(cfg_update) |-> !cfg_update [*8])
        else $error("commit burst split");
endmodule
`default_nettype wire

// File: tb/i2c_host_model.sv
// Bus master model for the two-wire port
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model
#(
    parameter int q_ns = 630
)
(
    // Bus pins
    output var logic scl,
    output var logic pull,
    input  wire logic sda
);
    // ********
    // Bus phases
    // ********
    initial
    begin
        scl  = 1'b1;
        pull = 1'b0;
    end
    // Quarter of 630 ns gives about 397 kHz, inside the band
    task automatic put_bit(input logic b);
        pull = !b;
        #q_ns scl = 1'b1;
        #(2*q_ns) scl = 1'b0;
        #q_ns;
    endtask
    task automatic get_bit(output logic b);
        pull = 1'b0;
        #q_ns scl = 1'b1;
        #q_ns b = sda;
        #q_ns scl = 1'b0;
        #q_ns;
    endtask
    // Also serves as repeated start
    task automatic start;
        pull = 1'b0;
        #q_ns scl = 1'b1;
        #(2*q_ns) pull = 1'b1;
        #(2*q_ns) scl = 1'b0;
        #q_ns;
    endtask
    task automatic stop;
        pull = 1'b1;
        #q_ns scl = 1'b1;
        #(2*q_ns) pull = 1'b0;
        #(2*q_ns);
    endtask
    // Whole bytes, top bit first
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(a);
        ack = !a;
    endtask
    // Acknowledge bit follows ack; callers pass 0 to leave the last byte unacknowledged
    task automatic rbyte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(!ack);
    endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the two-wire configuration port
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ********
    // Signals
    // ********
    logic        clk;
    logic        resetn;
    logic        scl;
    logic        pull;
    logic        restore_valid;
    logic [7:0]  restore_addr;
    logic [7:0]  restore_data;
    logic        restore_done;
    logic        sda_out;
    logic        sda_oe;
    logic [7:0]  cfg_addr;
    logic [7:0]  cfg_data;
    logic        cfg_update;
    logic        ready;
    logic        ack;
    logic [7:0]  rd;
    logic [15:0] upd[$];
    int          n_fail;
    int          cmp_count;
    // Pull-up: line is low only while some party pulls it
    wire logic   sda_line = !(pull || (sda_oe && !sda_out));
    i2c_host_model m (.scl(scl), .pull(pull), .sda(sda_line));
    i2c_cfg_port DUT (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .restore_valid(restore_valid),
        .restore_addr(restore_addr), .restore_data(restore_data),
        .restore_done(restore_done), .addr_select(1'b0), .cfg_addr(cfg_addr),
        .cfg_data(cfg_data), .cfg_update(cfg_update), .ready(ready)
    );
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (cfg_update === 1'b1)
            upd.push_back({cfg_addr, cfg_data});
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_unready;
        m.start;
        m.wbyte(8'hd4, ack);
        check(16'(ack), 16'h0000);
        m.stop;
        $display("t_unready done");
    endtask
    task automatic t_restore;
        @(negedge clk);
        restore_valid = 1'b1;
        restore_addr  = 8'h05;
        restore_data  = 8'h5a;
        @(negedge clk);
        restore_valid = 1'b0;
        restore_done  = 1'b1;
        @(negedge clk);
        restore_done  = 1'b0;
        repeat (4) @(negedge clk);
        check(16'(ready), 16'h0001);
        upd.delete();
        m.start;
        m.wbyte(8'hd0, ack);
        check(16'(ack), 16'h0000);
        m.stop;
        $display("t_restore done");
    endtask
    task automatic t_write;
        m.start;
        m.wbyte(8'hd4, ack);
        check(16'(ack), 16'h0001);
        m.wbyte(8'h10, ack);
        m.wbyte(8'ha5, ack);
        m.wbyte(8'h3c, ack);
        check(16'(ack), 16'h0001);
        check(16'(upd.size()), 16'h0000);
        m.stop;
        repeat (20) @(negedge clk);
        check(16'(upd.size()), 16'h0002);
        check(upd[0], 16'h10a5);
        check(upd[1], 16'h113c);
        upd.delete();
        $display("t_write done");
    endtask
    task automatic t_current;
        m.start;
        m.wbyte(8'hd4, ack);
        m.wbyte(8'h10, ack);
        m.stop;
        check(16'(upd.size()), 16'h0000);
        m.start;
        m.wbyte(8'hd5, ack);
        m.rbyte(1'b1, rd);
        check({8'h00, rd}, 16'h00a5);
        m.rbyte(1'b0, rd);
        check({8'h00, rd}, 16'h003c);
        m.stop;
        $display("t_current done");
    endtask
    task automatic t_seq;
        m.start;
        m.wbyte(8'hd4, ack);
        m.wbyte(8'h05, ack);
        m.start;
        m.wbyte(8'hd5, ack);
        check(16'(ack), 16'h0001);
        m.rbyte(1'b0, rd);
        check({8'h00, rd}, 16'h005a);
        m.stop;
        $display("t_seq done");
    endtask
    initial
    begin
        n_fail        = 0;
        cmp_count     = 0;
        resetn        = 1'b0;
        restore_valid = 1'b0;
        restore_addr  = 8'h00;
        restore_data  = 8'h00;
        restore_done  = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_unready;
        t_restore;
        t_write;
        t_current;
        t_seq;
        final_report;
    end
    // Scenarios need about 386 us of bus time
    initial
    begin
        #440000;
        n_fail++;
        final_report;
    end
endmodule
bind i2c_cfg_port i2c_cfg_port_assertions #(.regs(regs)) chk (
    .clk(clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .restore_done(restore_done), .cfg_addr(cfg_addr),
    .cfg_update(cfg_update), .ready(ready)
);
`default_nettype wire
